// ===== sdh_pkg.sv
package sdh_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [15:0] IDX_POINTER = 16'hFC7C;
	localparam logic [15:0] IDX_LENGTH = 16'hFC7D;
	localparam logic [15:0] IDX_CONFIG = 16'hFC7E;
	localparam logic [15:0] IDX_STATUS = 16'hFC7F;

	// Reset values
	localparam logic [10:0] POINTER_RST = 11'h000;
	localparam logic [15:0] LENGTH_RST = 16'h0000;
	localparam logic [12:0] CONFIG_RST = 13'h0000;
	localparam logic [4:0] DIVIDER_RST = 5'h00;

	// Writable configuration bits (9:8 reserved)
	localparam logic [12:0] CONFIG_WMASK = 13'h1CFF;
	localparam int POINTER_W = 11;

	// Status field positions
	localparam int DIV_LSB = 8;
	localparam int DIV_W = 5;
	localparam int RPM_BIT = 7;
	localparam int CMDBRK_BIT = 5;
	localparam int DAT0_BIT = 4;
	localparam int NOSTOP_BIT = 3;
	localparam int CRC16_BIT = 2;
	localparam int CRC7_BIT = 1;
	localparam int TMO_BIT = 0;

	// Card-side timing and checks
	localparam int HUNT_LIMIT = 256;
	localparam int CRC7_LEN = 7;
	localparam int CRC16_LEN = 16;
	localparam logic [6:0] CRC7_POLY = 7'h09;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam int PATTERN_BYTES = 512;

	typedef struct packed {
		logic skip_crc_send;
		logic keep_crc_running;
		logic wide_bus_select;
		logic [1:0] reserved;
		logic transfer_go;
		logic direction_select;
		logic command_or_data_select;
		logic omit_start_bit;
		logic omit_stop_bit;
		logic data_check_enable;
		logic command_check_enable;
		logic start_bit_hunt;
	} sdh_cfg_s;

	typedef struct packed {
		logic command_during_data_flag;
		logic missing_stop_flag;
		logic data_check_error;
		logic response_check_error;
		logic start_timeout_error;
	} sdh_err_s;

	typedef enum logic [3:0] {
		PH_IDLE, PH_ARM, PH_FETCH, PH_WAIT, PH_LOAD, PH_START, PH_HUNT,
		PH_DATA, PH_CRC, PH_STOP, PH_END
	} sdh_phase_e;
endpackage

// ===== sdh_card_host.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Memory pointer register holds an 11-bit peripheral-memory word address.
// - Length register counts bytes moved to or from the card.
// - Configuration bit 10 selects four data lines instead of one.
// - Setting configuration bit 7 starts a card transfer.
// - Configuration bit 6 high reads from the card, low writes.
// - Configuration bit 5 picks command line or data lines.
// - Configuration bit 4 omits the data start bit for continuation.
// - Configuration bit 3 omits the trailing stop bit for continuation.
// - Bit 2 enables 16-bit CRC, bit 1 enables 7-bit CRC.
// - Computed CRC is sent at transfer end unless bit 12 is set.
// - Bit 11 keeps the CRC register running across transfers.
// - Poll bit hunts a start bit; 256 card clocks without one times out.
// - Card clock period is 2*(status 12:8 + 1) system clocks.
// - Status bit 7 replays a 512-byte buffer endlessly on data lines.
// - Status bit 5 flags command start bit during data; cleared per op.
// - Status bit 4 shows the sampled level of data line zero.
// - Status bit 3 flags a missing stop bit after read data.
// - Status bit 2 flags a failed 16-bit data CRC check.
// - Status bit 1 flags a failed 7-bit response CRC check.
module sdh_card_host #(
	parameter int ADR_W = 18
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Wishbone register slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Peripheral memory, read data valid one cycle after the strobe
	output logic [10:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [15:0] MEM_WDATA,
	input wire logic [15:0] MEM_RDATA,
	// Card pins
	output logic SD_CLK,
	output logic SD_CMD_O,
	output logic SD_CMD_OE,
	input wire logic SD_CMD_I,
	output logic [3:0] SD_DAT_O,
	output logic [3:0] SD_DAT_OE,
	input wire logic [3:0] SD_DAT_I
);
	sdh_pkg::sdh_cfg_s cfg_r, run_r, start_cfg;
	sdh_pkg::sdh_err_s err_r, err_set;
	sdh_pkg::sdh_phase_e phase_r, tail;
	logic [10:0] ptr_r;
	logic [15:0] len_r;
	logic [4:0] div_r, div_cnt_r, bitcnt_r;
	logic rpm_r, rep_r;
	logic cmd_s1_r, cmd_s2_r;
	logic [3:0] dat_s1_r, dat_s2_r;
	logic [15:0] idx_r, nxt_idx, word_r;
	logic [7:0] byte_r, rx_byte, hunt_r;
	logic [6:0] crc7_r, crc7_n;
	logic [15:0] crc16_r [4];
	logic [15:0] crc16_n [4];
	logic [15:0] ptr_w, len_w, cfg_w, st_w, st_rd, rd_mux;
	logic [3:0] rx_bits, tx_bits, line_bits;
	logic req, wr_en, running, tick, rise, step, wide4, is_cmd, is_rd;
	logic bit_last, crc_last, crc_on, line0, last_byte, start_w;
	logic timeout, finish, bad16;

	function automatic logic [6:0] crc7_next(input logic [6:0] c,
		input logic b);
		logic fb;
		fb = b ^ c[6];
		return {c[5:0], 1'b0} ^ (fb ? sdh_pkg::CRC7_POLY : 7'h00);
	endfunction

	function automatic logic [15:0] crc16_next(input logic [15:0] c,
		input logic b);
		logic fb;
		fb = b ^ c[15];
		return {c[14:0], 1'b0} ^ (fb ? sdh_pkg::CRC16_POLY : 16'h0000);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic reg_hit(input logic [ADR_W-1:0] a,
		input logic [15:0] idx);
		return a == ADR_W'({idx, 2'b00});
	endfunction

	// Repeat mode locks the top three pointer bits, 256 words per buffer
	function automatic logic [10:0] word_addr(input logic [15:0] idx);
		if (rep_r) begin
			return {ptr_r[10:8], idx[8:1]};
		end
		return ptr_r + idx[11:1];
	endfunction

	// Bus decode and write-data merge
	always_comb begin
		req = WB_CYC_I && WB_STB_I;
		// Writes land on the edge where the master samples ack high
		wr_en = req && WB_WE_I && WB_ACK_O;
		ptr_w = merge16({5'h00, ptr_r}, WB_DAT_I, WB_SEL_I);
		len_w = merge16(len_r, WB_DAT_I, WB_SEL_I);
		cfg_w = merge16({3'b000, cfg_r}, WB_DAT_I, WB_SEL_I);
		st_w = merge16(st_rd, WB_DAT_I, WB_SEL_I);
		st_rd = 16'h0000;
		st_rd[sdh_pkg::DIV_LSB +: sdh_pkg::DIV_W] = div_r;
		st_rd[sdh_pkg::RPM_BIT] = rpm_r;
		st_rd[sdh_pkg::CMDBRK_BIT] = err_r.command_during_data_flag;
		st_rd[sdh_pkg::DAT0_BIT] = dat_s2_r[0];
		st_rd[sdh_pkg::NOSTOP_BIT] = err_r.missing_stop_flag;
		st_rd[sdh_pkg::CRC16_BIT] = err_r.data_check_error;
		st_rd[sdh_pkg::CRC7_BIT] = err_r.response_check_error;
		st_rd[sdh_pkg::TMO_BIT] = err_r.start_timeout_error;
		if (reg_hit(WB_ADR_I, sdh_pkg::IDX_POINTER)) begin
			rd_mux = {5'h00, ptr_r};
		end else if (reg_hit(WB_ADR_I, sdh_pkg::IDX_LENGTH)) begin
			rd_mux = len_r;
		end else if (reg_hit(WB_ADR_I, sdh_pkg::IDX_CONFIG)) begin
			rd_mux = {3'b000, cfg_r};
		end else if (reg_hit(WB_ADR_I, sdh_pkg::IDX_STATUS)) begin
			rd_mux = st_rd;
		end else begin
			rd_mux = 16'h0000;
		end
	end

	// Card-side datapath decode
	always_comb begin
		is_cmd = run_r.command_or_data_select;
		is_rd = run_r.direction_select;
		running = phase_r inside {sdh_pkg::PH_START, sdh_pkg::PH_HUNT,
			sdh_pkg::PH_DATA, sdh_pkg::PH_CRC, sdh_pkg::PH_STOP,
			sdh_pkg::PH_END};
		tick = running && div_cnt_r == div_r;
		rise = tick && !SD_CLK;
		step = is_rd ? rise : (tick && SD_CLK);
		wide4 = run_r.wide_bus_select && !is_cmd;
		bit_last = wide4 ? (bitcnt_r == 5'd1) : (bitcnt_r == 5'd7);
		crc_last = bitcnt_r == (is_cmd ? 5'(sdh_pkg::CRC7_LEN - 1) :
			5'(sdh_pkg::CRC16_LEN - 1));
		crc_on = is_cmd ? run_r.command_check_enable :
			run_r.data_check_enable;
		if (crc_on && !run_r.skip_crc_send) begin
			tail = sdh_pkg::PH_CRC;
		end else if (!run_r.omit_stop_bit) begin
			tail = sdh_pkg::PH_STOP;
		end else begin
			tail = sdh_pkg::PH_END;
		end
		line0 = is_cmd ? cmd_s2_r : dat_s2_r[0];
		rx_bits = is_cmd ? {3'b000, cmd_s2_r} :
			(wide4 ? dat_s2_r : {3'b000, dat_s2_r[0]});
		case (phase_r)
			sdh_pkg::PH_START: tx_bits = 4'h0;
			sdh_pkg::PH_DATA: tx_bits = wide4 ? byte_r[7:4] :
				{3'b000, byte_r[7]};
			sdh_pkg::PH_CRC: tx_bits = is_cmd ? {3'b000, crc7_r[6]} :
				{crc16_r[3][15], crc16_r[2][15], crc16_r[1][15],
				crc16_r[0][15]};
			default: tx_bits = 4'hF;
		endcase
		line_bits = is_rd ? rx_bits : tx_bits;
		crc7_n = crc7_next(crc7_r, line_bits[0]);
		for (int l = 0; l < 4; l++) begin
			crc16_n[l] = crc16_next(crc16_r[l], line_bits[l]);
		end
		bad16 = (crc16_n[0] != 16'h0000) || (wide4 &&
			(crc16_n[1] != 16'h0000 || crc16_n[2] != 16'h0000 ||
			crc16_n[3] != 16'h0000));
		rx_byte = wide4 ? {byte_r[3:0], rx_bits} : {byte_r[6:0], rx_bits[0]};
		nxt_idx = idx_r + 16'h0001;
		last_byte = !rep_r && nxt_idx == len_r;
		start_w = phase_r == sdh_pkg::PH_IDLE && (cfg_r.transfer_go ||
			rpm_r);
		start_cfg = cfg_r;
		if (!cfg_r.transfer_go) begin
			start_cfg = '0;
			start_cfg.wide_bus_select = cfg_r.wide_bus_select;
		end
		timeout = phase_r == sdh_pkg::PH_HUNT && step && line0 &&
			hunt_r == 8'(sdh_pkg::HUNT_LIMIT - 1);
		finish = (phase_r == sdh_pkg::PH_END && (is_rd || step)) || timeout;
		err_set.command_during_data_flag = running && !is_cmd && rise &&
			!cmd_s2_r;
		err_set.missing_stop_flag = is_rd && !is_cmd &&
			phase_r == sdh_pkg::PH_STOP && step &&
			(wide4 ? dat_s2_r != 4'hF : !dat_s2_r[0]);
		err_set.data_check_error = is_rd && !is_cmd &&
			phase_r == sdh_pkg::PH_CRC && step && crc_last && bad16;
		err_set.response_check_error = is_rd && is_cmd &&
			phase_r == sdh_pkg::PH_CRC && step && crc_last &&
			crc7_n != 7'h00;
		err_set.start_timeout_error = timeout;
	end

	// Two-stage synchronisers for card inputs
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cmd_s1_r <= 1'b1;
			cmd_s2_r <= 1'b1;
			dat_s1_r <= 4'hF;
			dat_s2_r <= 4'hF;
		end else begin
			cmd_s1_r <= SD_CMD_I;
			cmd_s2_r <= cmd_s1_r;
			dat_s1_r <= SD_DAT_I;
			dat_s2_r <= dat_s1_r;
		end
	end

	// Wishbone answer: ack one cycle after the request
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req && !WB_ACK_O;
			if (req && !WB_ACK_O) begin
				WB_DAT_O <= {16'h0000, rd_mux};
			end
		end
	end

	// Pointer, length and configuration
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ptr_r <= sdh_pkg::POINTER_RST;
			len_r <= sdh_pkg::LENGTH_RST;
			cfg_r <= sdh_pkg::CONFIG_RST;
		end else begin
			if (wr_en && reg_hit(WB_ADR_I, sdh_pkg::IDX_POINTER)) begin
				ptr_r <= ptr_w[sdh_pkg::POINTER_W-1:0];
			end
			if (wr_en && reg_hit(WB_ADR_I, sdh_pkg::IDX_LENGTH)) begin
				len_r <= len_w;
			end
			if (wr_en && reg_hit(WB_ADR_I, sdh_pkg::IDX_CONFIG)) begin
				cfg_r <= cfg_w[12:0] & sdh_pkg::CONFIG_WMASK;
			end else if (finish) begin
				cfg_r.transfer_go <= 1'b0;
			end
		end
	end

	// Status: divider and repeat enable written, error flags sticky
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_r <= sdh_pkg::DIVIDER_RST;
			rpm_r <= 1'b0;
			err_r <= '0;
		end else begin
			if (wr_en && reg_hit(WB_ADR_I, sdh_pkg::IDX_STATUS)) begin
				div_r <= st_w[sdh_pkg::DIV_LSB +: sdh_pkg::DIV_W];
				rpm_r <= st_w[sdh_pkg::RPM_BIT];
			end
			// A set in the same cycle as the start-of-op clear wins
			err_r <= (start_w ? '0 : err_r) | err_set;
		end
	end

	// Card clock: half period of div+1 cycles, held low while idle
	// and while a memory word is being fetched, so the card never
	// sees a bit edge without data behind it
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_cnt_r <= 5'h00;
			SD_CLK <= 1'b0;
		end else if (!running) begin
			div_cnt_r <= 5'h00;
			SD_CLK <= 1'b0;
		end else if (tick) begin
			div_cnt_r <= 5'h00;
			SD_CLK <= !SD_CLK;
		end else begin
			div_cnt_r <= div_cnt_r + 5'h01;
		end
	end

	// CRC registers
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			crc7_r <= 7'h00;
			for (int l = 0; l < 4; l++) begin
				crc16_r[l] <= 16'h0000;
			end
		end else if (start_w) begin
			if (!start_cfg.keep_crc_running) begin
				crc7_r <= 7'h00;
				for (int l = 0; l < 4; l++) begin
					crc16_r[l] <= 16'h0000;
				end
			end
		end else if (step && phase_r inside {sdh_pkg::PH_DATA,
			sdh_pkg::PH_CRC}) begin
			crc7_r <= crc7_n;
			for (int l = 0; l < 4; l++) begin
				if (l == 0 || wide4) begin
					crc16_r[l] <= crc16_n[l];
				end
			end
		end
	end

	// Pin drivers: new bit on each falling card clock while writing
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SD_CMD_O <= 1'b1;
			SD_CMD_OE <= 1'b0;
			SD_DAT_O <= 4'hF;
			SD_DAT_OE <= 4'h0;
		end else if (!is_rd && step) begin
			if (phase_r == sdh_pkg::PH_END) begin
				SD_CMD_OE <= 1'b0;
				SD_DAT_OE <= 4'h0;
			end else if (is_cmd) begin
				SD_CMD_O <= tx_bits[0];
				SD_CMD_OE <= 1'b1;
			end else begin
				SD_DAT_O <= tx_bits;
				SD_DAT_OE <= wide4 ? 4'hF : 4'h1;
			end
		end
	end

	// Transfer sequencer
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_r <= sdh_pkg::PH_IDLE;
			run_r <= '0;
			rep_r <= 1'b0;
			idx_r <= 16'h0000;
			bitcnt_r <= 5'h00;
			byte_r <= 8'h00;
			word_r <= 16'h0000;
			hunt_r <= 8'h00;
			MEM_ADDR <= 11'h000;
			MEM_RD <= 1'b0;
			MEM_WR <= 1'b0;
			MEM_WDATA <= 16'h0000;
		end else begin
			MEM_RD <= 1'b0;
			MEM_WR <= 1'b0;
			case (phase_r)
				sdh_pkg::PH_IDLE: begin
					if (start_w) begin
						run_r <= start_cfg;
						rep_r <= !cfg_r.transfer_go;
						idx_r <= 16'h0000;
						bitcnt_r <= 5'h00;
						hunt_r <= 8'h00;
						phase_r <= sdh_pkg::PH_ARM;
					end
				end
				sdh_pkg::PH_ARM: begin
					if (is_rd) begin
						if (run_r.start_bit_hunt) begin
							phase_r <= sdh_pkg::PH_HUNT;
						end else if (!run_r.omit_start_bit) begin
							phase_r <= sdh_pkg::PH_START;
						end else begin
							phase_r <= len_r == 16'h0000 ? tail :
								sdh_pkg::PH_DATA;
						end
					end else if (len_r == 16'h0000 && !rep_r) begin
						phase_r <= run_r.omit_start_bit ? tail :
							sdh_pkg::PH_START;
					end else begin
						phase_r <= sdh_pkg::PH_FETCH;
					end
				end
				sdh_pkg::PH_FETCH: begin
					MEM_RD <= 1'b1;
					MEM_ADDR <= word_addr(idx_r);
					phase_r <= sdh_pkg::PH_WAIT;
				end
				sdh_pkg::PH_WAIT: phase_r <= sdh_pkg::PH_LOAD;
				sdh_pkg::PH_LOAD: begin
					word_r <= MEM_RDATA;
					byte_r <= MEM_RDATA[15:8];
					if (idx_r == 16'h0000 && !rep_r &&
						!run_r.omit_start_bit) begin
						phase_r <= sdh_pkg::PH_START;
					end else begin
						phase_r <= sdh_pkg::PH_DATA;
					end
				end
				sdh_pkg::PH_START: begin
					if (step) begin
						phase_r <= len_r == 16'h0000 ? tail :
							sdh_pkg::PH_DATA;
					end
				end
				sdh_pkg::PH_HUNT: begin
					if (timeout) begin
						phase_r <= sdh_pkg::PH_IDLE;
					end else if (step && !line0) begin
						phase_r <= len_r == 16'h0000 ? tail :
							sdh_pkg::PH_DATA;
					end else if (step) begin
						hunt_r <= hunt_r + 8'h01;
					end
				end
				sdh_pkg::PH_DATA: begin
					if (step) begin
						bitcnt_r <= bitcnt_r + 5'h01;
						if (is_rd) begin
							byte_r <= rx_byte;
						end else begin
							byte_r <= wide4 ? {byte_r[3:0], 4'h0} :
								{byte_r[6:0], 1'b0};
						end
						if (bit_last) begin
							bitcnt_r <= 5'h00;
							idx_r <= rep_r ? {7'h00, nxt_idx[8:0]} : nxt_idx;
							if (is_rd && !idx_r[0]) begin
								word_r[15:8] <= rx_byte;
							end
							// Big-endian words; a lone last byte leaves low half 0
							if (is_rd && (idx_r[0] || last_byte)) begin
								MEM_WR <= 1'b1;
								MEM_ADDR <= word_addr(idx_r);
								MEM_WDATA <= idx_r[0] ? {word_r[15:8], rx_byte} :
									{rx_byte, 8'h00};
							end
							if (last_byte) begin
								phase_r <= tail;
							end else if (rep_r && !rpm_r) begin
								phase_r <= sdh_pkg::PH_END;
							end else if (!is_rd && !nxt_idx[0]) begin
								phase_r <= sdh_pkg::PH_FETCH;
							end else if (!is_rd) begin
								byte_r <= word_r[7:0];
							end
						end
					end
				end
				sdh_pkg::PH_CRC: begin
					if (step) begin
						bitcnt_r <= bitcnt_r + 5'h01;
						if (crc_last) begin
							bitcnt_r <= 5'h00;
							phase_r <= run_r.omit_stop_bit ? sdh_pkg::PH_END :
								sdh_pkg::PH_STOP;
						end
					end
				end
				sdh_pkg::PH_STOP: begin
					if (step) begin
						phase_r <= sdh_pkg::PH_END;
					end
				end
				sdh_pkg::PH_END: begin
					if (finish) begin
						phase_r <= sdh_pkg::PH_IDLE;
					end
				end
				default: phase_r <= sdh_pkg::PH_IDLE;
			endcase
		end
	end
endmodule // sdh_card_host

// ===== sdh_card_host_props.sv
`timescale 1ns/1ps
module sdh_card_host_props #(
	parameter int ADR_W = 18
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Register bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Card side
	input wire logic SD_CLK,
	input wire logic SD_CMD_OE,
	input wire logic [3:0] SD_DAT_OE
);
	logic req;
	logic rd_r;
	logic [ADR_W-1:0] adr_r;
	logic [4:0] div_r;
	logic wide_r;
	logic cmd_r;
	logic [5:0] hi_r;
	function automatic logic hit(input logic [ADR_W-1:0] a,
		input logic [15:0] i);
		return a == ADR_W'({i, 2'b00});
	endfunction
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rd_r <= 1'b0;
			adr_r <= '0;
		end else if (req) begin
			rd_r <= !WB_WE_I;
			adr_r <= WB_ADR_I;
		end
	end
	// Shadow of the controls; the bench writes new values only while idle
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_r <= '0;
			wide_r <= 1'b0;
			cmd_r <= 1'b0;
		end else if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I &&
			WB_SEL_I[1:0] == 2'b11) begin
			if (hit(WB_ADR_I, sdh_pkg::IDX_STATUS))
				div_r <= WB_DAT_I[12:8];
			if (hit(WB_ADR_I, sdh_pkg::IDX_CONFIG)) begin
				wide_r <= WB_DAT_I[10];
				cmd_r <= WB_DAT_I[5];
			end
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			hi_r <= '0;
		else
			hi_r <= SD_CLK ? hi_r + 6'h01 : 6'h00;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (req |=> WB_ACK_O)
		else $error("request not answered next cycle");
	ack_cause_a: assert property (WB_ACK_O |-> $past(req))
		else $error("ack without request");
	upper_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0)
		else $error("upper read half not zero");
	pointer_width_a: assert property (WB_ACK_O && rd_r &&
		hit(adr_r, sdh_pkg::IDX_POINTER) |-> WB_DAT_O[15:11] == 5'h00)
		else $error("pointer wider than eleven bits");
	unmapped_zero_a: assert property (WB_ACK_O && rd_r &&
		!(hit(adr_r, sdh_pkg::IDX_POINTER) || hit(adr_r, sdh_pkg::IDX_LENGTH)
		|| hit(adr_r, sdh_pkg::IDX_CONFIG) || hit(adr_r, sdh_pkg::IDX_STATUS))
		|-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	clock_high_a: assert property ($fell(SD_CLK) && (|SD_DAT_OE)
		|-> hi_r == {1'b0, div_r} + 6'h01)
		else $error("card clock high phase wrong");
	narrow_bus_a: assert property (!wide_r |-> SD_DAT_OE[3:1] == 3'h0)
		else $error("upper lanes driven in narrow mode");
	cmd_quiet_a: assert property (!cmd_r |-> !SD_CMD_OE)
		else $error("command line driven in data mode");
	cover property ($fell(SD_CLK) && SD_DAT_OE[3]);
	cover property ($fell(SD_DAT_OE[0]));
	cover property ($fell(SD_CMD_OE));
	cover property (WB_ACK_O && rd_r && hit(adr_r, sdh_pkg::IDX_STATUS));
endmodule // sdh_card_host_props

bind sdh_card_host sdh_card_host_props #(.ADR_W(ADR_W)) props_i (
	.CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.SD_CLK(SD_CLK), .SD_CMD_OE(SD_CMD_OE), .SD_DAT_OE(SD_DAT_OE)
);

// ===== sdh_card_model.sv
`timescale 1ns/1ps
module sdh_card_model (
	// Card pins
	input wire logic SD_CLK,
	input wire logic SD_CMD_O,
	input wire logic SD_CMD_OE,
	output logic SD_CMD_I,
	input wire logic [3:0] SD_DAT_O,
	input wire logic [3:0] SD_DAT_OE,
	output logic [3:0] SD_DAT_I,
	// Bench control and capture
	input wire logic hold_low,
	input wire logic cmd_low,
	output logic [15:0] lane0_bits,
	output logic [15:0] nibbles,
	output logic [7:0] samples
);
	// Lines carry pull-ups, so a released line reads high unless cmd_low or hold_low pulls it low
	assign SD_CMD_I = SD_CMD_OE ? SD_CMD_O : !cmd_low;
	assign SD_DAT_I = (SD_DAT_OE & SD_DAT_O) |
		(~SD_DAT_OE & {3'b111, !hold_low});
	initial begin
		lane0_bits = 16'h0000;
		nibbles = 16'h0000;
		samples = 8'h00;
	end
	// The card samples on the rising card clock edge; lane0_bits follows
	// whichever of command line or data line zero the host drives
	always @(posedge SD_CLK) begin
		if (SD_CMD_OE || SD_DAT_OE[0]) begin
			lane0_bits <= {lane0_bits[14:0],
				SD_CMD_OE ? SD_CMD_I : SD_DAT_I[0]};
			samples <= samples + 8'h01;
		end
		if (SD_DAT_OE[0]) begin
			nibbles <= {nibbles[11:0], SD_DAT_I};
		end
	end
endmodule // sdh_card_model

// ===== sdh_card_host_bench.sv
`timescale 1ns/1ps
module sdh_card_host_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [17:0] adr = '0;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic ack;
	logic mem_rd, mem_wr;
	logic [10:0] mem_addr;
	logic [10:0] maddr = 11'h000;
	logic [15:0] mem_wdata;
	logic [15:0] mwdata = 16'hFFFF;
	logic cmd_low = 1'b0;
	logic [7:0] base;
	logic [15:0] mrdata = 16'h0000;
	logic sd_clk, cmd_o, cmd_oe, cmd_i;
	logic [3:0] dat_o, dat_oe, dat_i;
	logic hold_low = 1'b0;
	logic [15:0] lane0_bits, nibbles;
	logic [7:0] samples;
	logic [31:0] q;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	// Memory answers the cycle after the strobe, then shows junk
	always @(posedge clk)
		mrdata <= mem_rd ? 16'hA53C : ~mrdata;
	// Keeps the last word the block stored to memory
	always @(posedge clk)
		if (mem_wr) begin
			maddr <= mem_addr;
			mwdata <= mem_wdata;
		end
	sdh_card_host dut (
		.CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .MEM_ADDR(mem_addr),
		.MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata),
		.MEM_RDATA(mrdata), .SD_CLK(sd_clk),
		.SD_CMD_O(cmd_o), .SD_CMD_OE(cmd_oe), .SD_CMD_I(cmd_i),
		.SD_DAT_O(dat_o), .SD_DAT_OE(dat_oe), .SD_DAT_I(dat_i)
	);
	sdh_card_model card (
		.SD_CLK(sd_clk), .SD_CMD_O(cmd_o), .SD_CMD_OE(cmd_oe),
		.SD_CMD_I(cmd_i), .SD_DAT_O(dat_o), .SD_DAT_OE(dat_oe),
		.SD_DAT_I(dat_i), .hold_low(hold_low), .cmd_low(cmd_low),
		.lane0_bits(lane0_bits),
		.nibbles(nibbles), .samples(samples)
	);
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [15:0] idx, input logic w,
		input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {16'h0000, d};
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_check(input logic [15:0] idx, input logic [31:0] e);
		wb(idx, 1'b0, 16'h0000);
		check(q, e);
	endtask
	task automatic wait_done;
		q = 32'h0000_0080;
		while (q[7] !== 1'b0)
			wb(sdh_pkg::IDX_CONFIG, 1'b0, 16'h0000);
		while (dat_oe !== 4'h0)
			@(posedge clk);
	endtask
	// Starts one transfer and checks bit count and the last captured bits
	task automatic xfer(input logic [15:0] cfg, input logic [7:0] n,
		input logic [15:0] m, input logic [15:0] bits);
		logic [7:0] s0;
		s0 = samples;
		wb(sdh_pkg::IDX_CONFIG, 1'b1, cfg);
		wait_done;
		check(32'(8'(samples - s0)), 32'(n));
		check(32'(lane0_bits & m), 32'(bits));
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_check(sdh_pkg::IDX_POINTER, 32'h0);
		rd_check(sdh_pkg::IDX_LENGTH, 32'h0);
		rd_check(sdh_pkg::IDX_CONFIG, 32'h0);
		rd_check(sdh_pkg::IDX_STATUS, 32'h10);
		wb(sdh_pkg::IDX_POINTER, 1'b1, 16'hFFFF);
		rd_check(sdh_pkg::IDX_POINTER, 32'h07FF);
		wb(sdh_pkg::IDX_LENGTH, 1'b1, 16'hBEEF);
		rd_check(sdh_pkg::IDX_LENGTH, 32'hBEEF);
		wb(sdh_pkg::IDX_CONFIG, 1'b1, 16'hE300);
		rd_check(sdh_pkg::IDX_CONFIG, 32'h0);
		wb(sdh_pkg::IDX_STATUS, 1'b1, 16'h1F40);
		rd_check(sdh_pkg::IDX_STATUS, 32'h1F10);
		wb(16'hFC70, 1'b1, 16'h1234);
		rd_check(16'hFC70, 32'h0);
		wb(sdh_pkg::IDX_POINTER, 1'b1, 16'h0123);
		wb(sdh_pkg::IDX_LENGTH, 1'b1, 16'h0001);
		wb(sdh_pkg::IDX_STATUS, 1'b1, 16'h0200);
		// Hunting read with no card answer must give up
		wb(sdh_pkg::IDX_CONFIG, 1'b1, 16'h00C1);
		wait_done;
		rd_check(sdh_pkg::IDX_STATUS, 32'h0211);
		rd_check(sdh_pkg::IDX_CONFIG, 32'h0041);
		hold_low <= 1'b1;
		repeat (4) @(posedge clk);
		rd_check(sdh_pkg::IDX_STATUS, 32'h0201);
		// Read of one byte with line zero low: zeros, no stop bit
		wb(sdh_pkg::IDX_CONFIG, 1'b1, 16'h00C0);
		wait_done;
		rd_check(sdh_pkg::IDX_STATUS, 32'h0208);
		check(32'(mwdata), 32'h0000);
		hold_low <= 1'b0;
		repeat (4) @(posedge clk);
		// All-ones read cannot carry a valid data check
		wb(sdh_pkg::IDX_CONFIG, 1'b1, 16'h00C4);
		wait_done;
		rd_check(sdh_pkg::IDX_STATUS, 32'h0214);
		check(32'(mwdata), 32'hFF00);
		check(32'(maddr), 32'h0123);
		cmd_low <= 1'b1;
		xfer(16'h0080, 8'd10, 16'h03FF, {7'h0, 8'hA5, 1'b1});
		rd_check(sdh_pkg::IDX_STATUS, 32'h0230);
		cmd_low <= 1'b0;
		xfer(16'h0098, 8'd8, 16'h00FF, 16'h00A5);
		xfer(16'h1084, 8'd10, 16'h03FF, {7'h0, 8'hA5, 1'b1});
		xfer(16'h0884, 8'd26, 16'hFFFF, 16'h0F89);
		xfer(16'h0084, 8'd26, 16'hFFFF, 16'hCA9F);
		xfer(16'h00A2, 8'd17, 16'hFFFF, 16'hA5BD);
		xfer(16'h0480, 8'd4, 16'h0001, 16'h0001);
		check(32'(nibbles), 32'h0A5F);
		rd_check(sdh_pkg::IDX_STATUS, 32'h0210);
		// Repeat mode with only the bus width left set in configuration
		base = samples;
		wb(sdh_pkg::IDX_STATUS, 1'b1, 16'h0280);
		while (8'(samples - base) != 8'd6)
			@(posedge clk);
		wb(sdh_pkg::IDX_STATUS, 1'b1, 16'h0200);
		wait_done;
		check(32'(8'(samples - base)), 32'd8);
		check(32'(nibbles), 32'hA53C);
		conclude();
	end
endmodule // sdh_card_host_bench
